// File: test/sti_jtag_host.sv
// Model of the external scan controller: drives test clock, mode and data.
// Assumes its tasks are called by the bench; the test clock rests low between frames.
`default_nettype none
module sti_jtag_host (
  input wire logic clk_i,
  input wire logic tdo_i,
  output logic tck_o,
  output logic tms_o,
  output logic tdi_o
);
  timeunit 1ns;
  timeprecision 1ps;
  initial
  begin
    tck_o = 1'b0;
    tms_o = 1'b1;
    tdi_o = 1'b0;
  end
  // 160 ns period, 5 clocks low so data out has settled before the rise
  task automatic pulse(input logic m, input logic d, output logic q);
    @(posedge clk_i);
    #1;
    tms_o = m;
    tdi_o = d;
    repeat (4) @(posedge clk_i);
    #1;
    q = tdo_i;
    tck_o = 1'b1;
    repeat (3) @(posedge clk_i);
    #1;
    tck_o = 1'b0;
  endtask : pulse
  task automatic go_idle();
    logic q;
    repeat (5) pulse(1'b1, 1'b0, q);
    pulse(1'b0, 1'b0, q);
  endtask : go_idle
  task automatic load_ir(input logic [2:0] code, output logic [2:0] cap);
    logic q;
    pulse(1'b1, 1'b0, q);
    pulse(1'b1, 1'b0, q);
    pulse(1'b0, 1'b0, q);
    pulse(1'b0, 1'b0, q);
    for (int i = 0; i < 3; i++)
    begin
      pulse(i == 2, code[i], q);
      cap[i] = q;
    end
    pulse(1'b1, 1'b0, q);
    pulse(1'b0, 1'b0, q);
  endtask : load_ir
  task automatic scan_dr(input int n, input logic [31:0] din, output logic [31:0] dout);
    logic q;
    dout = 32'h0000_0000;
    pulse(1'b1, 1'b0, q);
    pulse(1'b0, 1'b0, q);
    pulse(1'b0, 1'b0, q);
    for (int i = 0; i < n; i++)
    begin
      pulse(i == n - 1, din[i], q);
      dout[i] = q;
    end
    pulse(1'b1, 1'b0, q);
    pulse(1'b0, 1'b0, q);
  endtask : scan_dr
endmodule : sti_jtag_host
`default_nettype wire

// File: test/sti_tap_assertions.sv
// Concurrent checks on the scan-port decoder top, attached by bind.
// Assumes the test clock pin stays low at least 5 system clocks per period.
`default_nettype none
module sti_tap_assertions #(
  parameter int unsigned BSR_LEN = 16,
  parameter int unsigned LOG_DEPTH = 4
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic tck_i,
  input wire logic tdo_o,
  input wire logic tdo_oe_o,
  input wire logic outputs_float_o,
  input wire logic bsr_drive_o,
  input wire logic [BSR_LEN-1:0] bsr_pins_o,
  input wire logic instr_valid_o,
  input wire logic [2:0] instr_data_o,
  input wire logic instr_ready_i
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (rst_i);
  reset_quiet_a: assert property (disable iff (1'b0)
    rst_i |=> !tdo_oe_o && !outputs_float_o && !bsr_drive_o && !instr_valid_o)
    else $error("outputs active after reset");
  float_drive_excl_a: assert property (!(outputs_float_o && bsr_drive_o))
    else $error("float and drive both set");
  instr_hold_a: assert property (
    instr_valid_o && !instr_ready_i |=> instr_valid_o && $stable(instr_data_o))
    else $error("logged code lost before taken");
  tdo_on_fall_a: assert property ($changed(tdo_o) |-> !$past(tck_i, 2))
    else $error("test data out moved without a clock fall");
  oe_on_fall_a: assert property ($changed(tdo_oe_o) |-> !$past(tck_i, 2))
    else $error("data out enable moved without a clock fall");
  pins_on_fall_a: assert property ($changed(bsr_pins_o) |-> !$past(tck_i, 2))
    else $error("pin latch moved without a clock fall");
  float_on_update_a: assert property ($rose(outputs_float_o) |-> !$past(tck_i, 3))
    else $error("float rose without an update fall");
  valid_on_update_a: assert property ($rose(instr_valid_o) |-> !$past(tck_i, 3))
    else $error("code logged without an update fall");
endmodule : sti_tap_assertions
`default_nettype wire

// File: test/sti_tap_bench.sv
// Self-checking bench: decoder top, controller model and a code consumer.
// Assumes the design package and modules are compiled first.
`default_nettype none
module sti_tap_bench;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk_i, rst_i, tck, tms, tdi, tdo, tdo_oe, flt, drv, ivalid, iready;
  logic [2:0] idata;
  logic tdo_line;
  // Released data out reads high through the board pull-up
  assign tdo_line = tdo_oe ? tdo : 1'b1;
  logic [15:0] ring, pins;
  logic [2:0] got_q[$];
  int n_mismatch = 0;
  int checks_done = 0;
  sti_tap #(.BSR_LEN(16), .LOG_DEPTH(4)) sti_tap_inst (
    .clk_i(clk_i), .rst_i(rst_i), .tck_i(tck), .tms_i(tms), .tdi_i(tdi),
    .io_ring_i(ring), .tdo_o(tdo), .tdo_oe_o(tdo_oe), .outputs_float_o(flt),
    .bsr_drive_o(drv), .bsr_pins_o(pins), .instr_valid_o(ivalid),
    .instr_data_o(idata), .instr_ready_i(iready));
  sti_jtag_host sti_jtag_host_inst (
    .clk_i(clk_i), .tdo_i(tdo_line), .tck_o(tck), .tms_o(tms), .tdi_o(tdi));
  initial
  begin
    clk_i = 1'b0;
    forever #10 clk_i = ~clk_i;
  end
  always @(posedge clk_i)
    if (ivalid === 1'b1 && iready === 1'b1)
      got_q.push_back(idata);
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : check
  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", checks_done, n_mismatch);
    if (n_mismatch == 0 && checks_done > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask : tally_and_finish
  task automatic sc_reset_id();
    logic [31:0] d;
    check({tdo_oe, flt, drv, ivalid}, 4'h0);
    sti_jtag_host_inst.go_idle();
    sti_jtag_host_inst.scan_dr(32, 32'h0000_0000, d);
    check(d, sti_pkg::ID_VALUE);
  endtask : sc_reset_id
  // Two bits out tell the path: bypass gives 0 then data in, ring gives 0 then 1
  task automatic sc_codes();
    logic [2:0] cap;
    logic [31:0] d;
    logic [1:0] exp;
    for (int c = 0; c < 8; c++)
    begin
      sti_jtag_host_inst.load_ir(c[2:0], cap);
      check(cap, sti_pkg::IR_CAPTURE);
      check(got_q.size(), 1);
      check(got_q.pop_front(), c);
      check({flt, drv}, {c == 2, c == 0});
      sti_jtag_host_inst.scan_dr(2, 32'h0000_0000, d);
      exp = (c == 1) ? sti_pkg::ID_VALUE[1:0] : (c == 0 || c == 2 || c == 4) ? ring[1:0] : 2'b00;
      check(d, exp);
      if (c == 0)
        check(pins, 16'h0001);
    end
  endtask : sc_codes
  // Full log holds the fifth code back until the consumer drains it
  task automatic sc_full();
    logic [2:0] cap;
    logic [31:0] d;
    int k;
    @(posedge clk_i);
    #1;
    iready = 1'b0;
    repeat (4) sti_jtag_host_inst.load_ir(sti_pkg::IR_BYPASS, cap);
    sti_jtag_host_inst.load_ir(sti_pkg::IR_SAMPLE_Z, cap);
    check(flt, 1'b0);
    @(posedge clk_i);
    #1;
    iready = 1'b1;
    k = 0;
    while (flt !== 1'b1 && k < 50)
    begin
      @(posedge clk_i);
      k++;
    end
    if (k == 50)
    begin
      n_mismatch++;
      tally_and_finish();
    end
    repeat (10) @(posedge clk_i);
    check(got_q.size(), 5);
    check({got_q[3], got_q[4]}, {sti_pkg::IR_BYPASS, sti_pkg::IR_SAMPLE_Z});
    sti_jtag_host_inst.go_idle();
    check(flt, 1'b0);
    sti_jtag_host_inst.scan_dr(2, 32'h0000_0000, d);
    check(d, {30'h0000_0000, sti_pkg::ID_VALUE[1:0]});
  endtask : sc_full
  // Reset in mid-run drops the float code at once and empties the code log
  task automatic sc_mid_reset();
    logic [2:0] cap;
    logic [31:0] d;
    int n;
    @(posedge clk_i);
    #1;
    iready = 1'b0;
    n = got_q.size();
    sti_jtag_host_inst.load_ir(sti_pkg::IR_SAMPLE_Z, cap);
    check({flt, ivalid}, 2'b11);
    @(posedge clk_i);
    #1;
    rst_i = 1'b1;
    repeat (2) @(posedge clk_i);
    #1;
    rst_i = 1'b0;
    iready = 1'b1;
    @(posedge clk_i);
    #1;
    check({flt, drv, ivalid, tdo_oe}, 4'h0);
    sti_jtag_host_inst.go_idle();
    sti_jtag_host_inst.scan_dr(32, 32'h0000_0000, d);
    check(d, sti_pkg::ID_VALUE);
    check(got_q.size(), n);
  endtask : sc_mid_reset
  initial
  begin
    rst_i = 1'b1;
    iready = 1'b1;
    ring = 16'h0006;
    repeat (12) @(posedge clk_i);
    #1;
    rst_i = 1'b0;
    repeat (3) @(posedge clk_i);
    sc_reset_id();
    sc_codes();
    sc_full();
    sc_mid_reset();
    tally_and_finish();
  end
  initial
  begin
    repeat (100000) @(posedge clk_i);
    n_mismatch++;
    tally_and_finish();
  end
endmodule : sti_tap_bench
bind sti_tap sti_tap_assertions #(.BSR_LEN(BSR_LEN), .LOG_DEPTH(LOG_DEPTH))
  sti_tap_assertions_inst (.clk_i(clk_i), .rst_i(rst_i), .tck_i(tck_i), .tdo_o(tdo_o),
  .tdo_oe_o(tdo_oe_o), .outputs_float_o(outputs_float_o), .bsr_drive_o(bsr_drive_o),
  .bsr_pins_o(bsr_pins_o), .instr_valid_o(instr_valid_o), .instr_data_o(instr_data_o),
  .instr_ready_i(instr_ready_i));
`default_nettype wire

// File: verilog/sti_fifo.sv
// Small synchronous FIFO with valid/ready on both sides.
// Assumes one clock and a synchronous active-high reset.
`default_nettype none

module sti_fifo #(
  parameter int unsigned WIDTH = 3,
  parameter int unsigned DEPTH = 4
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic in_valid_i,
  output logic in_ready_o,
  input wire logic [WIDTH-1:0] in_data_i,
  output logic out_valid_o,
  input wire logic out_ready_i,
  output logic [WIDTH-1:0] out_data_o
);

  localparam int unsigned AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0] wr_ptr;
  logic [AW-1:0] rd_ptr;
  logic [AW:0] count;
  logic [AW-1:0] next_wr_ptr;
  logic [AW-1:0] next_rd_ptr;
  logic [AW:0] next_count;
  logic push;
  logic pop;

  assign in_ready_o = (count != DEPTH[AW:0]);
  assign out_valid_o = (count != '0);
  assign out_data_o = mem[rd_ptr];
  assign push = in_valid_i && in_ready_o;
  assign pop = out_valid_o && out_ready_i;

  always_comb
  begin
    next_wr_ptr = wr_ptr;
    next_rd_ptr = rd_ptr;
    next_count = count;
    if (push)
    begin
      next_wr_ptr = (wr_ptr == AW'(DEPTH - 1)) ? '0 : AW'(wr_ptr + 1'b1);
    end
    if (pop)
    begin
      next_rd_ptr = (rd_ptr == AW'(DEPTH - 1)) ? '0 : AW'(rd_ptr + 1'b1);
    end
    if (push && !pop)
    begin
      next_count = (AW + 1)'(count + 1'b1);
    end
    else if (pop && !push)
    begin
      next_count = (AW + 1)'(count - 1'b1);
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      count <= '0;
    end
    else
    begin
      wr_ptr <= next_wr_ptr;
      rd_ptr <= next_rd_ptr;
      count <= next_count;
    end
  end

  // Storage needs no reset; empty flag hides stale words
  always_ff @(posedge clk_i)
  begin
    if (push)
    begin
      mem[wr_ptr] <= in_data_i;
    end
  end

endmodule : sti_fifo

`default_nettype wire

// File: verilog/sti_pkg.sv
// Constants for the scan-port instruction decoder of the burst memory.
// Assumes a single 50 MHz system clock; the test clock arrives as a plain pin.
`default_nettype none

package sti_pkg;

  localparam int unsigned IR_WIDTH = 3;
  localparam int unsigned ID_WIDTH = 32;
  localparam int unsigned SYNC_STAGES = 2;

  // Instruction codes, most significant bit written leftmost
  localparam logic [2:0] IR_EXTEST = 3'h0;
  localparam logic [2:0] IR_IDCODE = 3'h1;
  localparam logic [2:0] IR_SAMPLE_Z = 3'h2;
  localparam logic [2:0] IR_RESERVED_A = 3'h3;
  localparam logic [2:0] IR_SAMPLE_PRELOAD = 3'h4;
  localparam logic [2:0] IR_PRIVATE = 3'h5;
  localparam logic [2:0] IR_RESERVED_B = 3'h6;
  localparam logic [2:0] IR_BYPASS = 3'h7;

  // Pattern forced into the instruction shifter in Capture-IR
  localparam logic [2:0] IR_CAPTURE = 3'h1;
  localparam logic [2:0] IR_RESET = IR_IDCODE;

  // Identification word; the value is arbitrary, bit 0 is the presence bit
  localparam logic [31:0] ID_VALUE = 32'h0000_0A5F;

  localparam logic BYPASS_CAPTURE = 1'b0;
  localparam logic TDO_RESET = 1'b0;

  typedef enum logic [3:0] {
    ST_RESET = 4'h0,
    ST_IDLE = 4'h1,
    ST_SEL_DR = 4'h3,
    ST_CAP_DR = 4'h2,
    ST_SH_DR = 4'h6,
    ST_EX1_DR = 4'h7,
    ST_PA_DR = 4'h5,
    ST_EX2_DR = 4'h4,
    ST_UPD_DR = 4'hC,
    ST_SEL_IR = 4'hD,
    ST_CAP_IR = 4'hF,
    ST_SH_IR = 4'hE,
    ST_EX1_IR = 4'hA,
    ST_PA_IR = 4'hB,
    ST_EX2_IR = 4'h9,
    ST_UPD_IR = 4'h8
  } sti_state_e;

  typedef enum logic [1:0] {
    SEL_BSR = 2'h0,
    SEL_ID = 2'h1,
    SEL_BYP = 2'h2
  } sti_sel_e;

endpackage : sti_pkg

`default_nettype wire

// File: verilog/sti_tap.sv
// Scan test port of a synchronous burst memory: state machine, instruction
// decode and the scan data registers. The test clock is sampled as a pin by
// the 50 MHz system clock; it must stay well below half that rate.
`default_nettype none

module sti_tap #(
  parameter int unsigned BSR_LEN = 16,
  parameter int unsigned LOG_DEPTH = 4
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic tck_i,
  input wire logic tms_i,
  input wire logic tdi_i,
  input wire logic [BSR_LEN-1:0] io_ring_i,
  output logic tdo_o,
  output logic tdo_oe_o,
  output logic outputs_float_o,
  output logic bsr_drive_o,
  output logic [BSR_LEN-1:0] bsr_pins_o,
  output logic instr_valid_o,
  output logic [2:0] instr_data_o,
  input wire logic instr_ready_i
);

  // Selects the scan register that a code places in the path
  function automatic sti_pkg::sti_sel_e sel_of(input logic [2:0] code);
    sti_pkg::sti_sel_e sel;
    sel = sti_pkg::SEL_BYP;
    case (code)
      sti_pkg::IR_EXTEST: sel = sti_pkg::SEL_BSR;
      sti_pkg::IR_IDCODE: sel = sti_pkg::SEL_ID;
      sti_pkg::IR_SAMPLE_Z: sel = sti_pkg::SEL_BSR;
      sti_pkg::IR_SAMPLE_PRELOAD: sel = sti_pkg::SEL_BSR;
      sti_pkg::IR_RESERVED_A: sel = sti_pkg::SEL_BYP;
      sti_pkg::IR_RESERVED_B: sel = sti_pkg::SEL_BYP;
      sti_pkg::IR_PRIVATE: sel = sti_pkg::SEL_BYP;
      sti_pkg::IR_BYPASS: sel = sti_pkg::SEL_BYP;
      default: sel = sti_pkg::SEL_BYP;
    endcase
    return sel;
  endfunction : sel_of

  function automatic sti_pkg::sti_state_e step(input sti_pkg::sti_state_e st,
                                               input logic tms);
    sti_pkg::sti_state_e nx;
    nx = st;
    case (st)
      sti_pkg::ST_RESET: nx = tms ? sti_pkg::ST_RESET : sti_pkg::ST_IDLE;
      sti_pkg::ST_IDLE: nx = tms ? sti_pkg::ST_SEL_DR : sti_pkg::ST_IDLE;
      sti_pkg::ST_SEL_DR: nx = tms ? sti_pkg::ST_SEL_IR : sti_pkg::ST_CAP_DR;
      sti_pkg::ST_CAP_DR: nx = tms ? sti_pkg::ST_EX1_DR : sti_pkg::ST_SH_DR;
      sti_pkg::ST_SH_DR: nx = tms ? sti_pkg::ST_EX1_DR : sti_pkg::ST_SH_DR;
      sti_pkg::ST_EX1_DR: nx = tms ? sti_pkg::ST_UPD_DR : sti_pkg::ST_PA_DR;
      sti_pkg::ST_PA_DR: nx = tms ? sti_pkg::ST_EX2_DR : sti_pkg::ST_PA_DR;
      sti_pkg::ST_EX2_DR: nx = tms ? sti_pkg::ST_UPD_DR : sti_pkg::ST_SH_DR;
      sti_pkg::ST_UPD_DR: nx = tms ? sti_pkg::ST_SEL_DR : sti_pkg::ST_IDLE;
      sti_pkg::ST_SEL_IR: nx = tms ? sti_pkg::ST_RESET : sti_pkg::ST_CAP_IR;
      sti_pkg::ST_CAP_IR: nx = tms ? sti_pkg::ST_EX1_IR : sti_pkg::ST_SH_IR;
      sti_pkg::ST_SH_IR: nx = tms ? sti_pkg::ST_EX1_IR : sti_pkg::ST_SH_IR;
      sti_pkg::ST_EX1_IR: nx = tms ? sti_pkg::ST_UPD_IR : sti_pkg::ST_PA_IR;
      sti_pkg::ST_PA_IR: nx = tms ? sti_pkg::ST_EX2_IR : sti_pkg::ST_PA_IR;
      sti_pkg::ST_EX2_IR: nx = tms ? sti_pkg::ST_UPD_IR : sti_pkg::ST_SH_IR;
      sti_pkg::ST_UPD_IR: nx = tms ? sti_pkg::ST_SEL_DR : sti_pkg::ST_IDLE;
      default: nx = sti_pkg::ST_RESET;
    endcase
    return nx;
  endfunction : step

  // Pin synchronisers; only the second stage is read by logic
  logic [2:0] pin_s1;
  logic [2:0] pin_s2;
  logic tck_prev;
  logic [BSR_LEN-1:0] ring_s1;
  logic [BSR_LEN-1:0] ring_s2;
  logic tck_s;
  logic tms_s;
  logic tdi_s;
  logic rise;
  logic fall;

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      pin_s1 <= '0;
      pin_s2 <= '0;
      tck_prev <= 1'b0;
      ring_s1 <= '0;
      ring_s2 <= '0;
    end
    else
    begin
      pin_s1 <= {tck_i, tms_i, tdi_i};
      pin_s2 <= pin_s1;
      tck_prev <= pin_s2[2];
      ring_s1 <= io_ring_i;
      ring_s2 <= ring_s1;
    end
  end

  assign tck_s = pin_s2[2];
  assign tms_s = pin_s2[1];
  assign tdi_s = pin_s2[0];
  assign rise = tck_s && !tck_prev;
  assign fall = !tck_s && tck_prev;

  sti_pkg::sti_state_e state;
  sti_pkg::sti_state_e next_state;
  logic [2:0] ir;
  logic [2:0] next_ir;
  logic [2:0] ir_sh;
  logic [2:0] next_ir_sh;
  logic byp;
  logic next_byp;
  logic [31:0] id_sh;
  logic [31:0] next_id_sh;
  logic [BSR_LEN-1:0] bsr;
  logic [BSR_LEN-1:0] next_bsr;
  logic [BSR_LEN-1:0] bsr_upd;
  logic [BSR_LEN-1:0] next_bsr_upd;
  logic tdo;
  logic next_tdo;
  logic tdo_oe;
  logic next_tdo_oe;
  logic upd_pend;
  logic next_upd_pend;
  logic push;
  logic fifo_ready;
  sti_pkg::sti_sel_e sel;

  assign sel = sel_of(ir);

  // A new code is logged through the FIFO; a full FIFO holds the update back,
  // so the code takes effect once the consumer drains a slot.
  assign push = upd_pend && fifo_ready;

  always_comb
  begin
    next_state = state;
    next_ir = ir;
    next_ir_sh = ir_sh;
    next_byp = byp;
    next_id_sh = id_sh;
    next_bsr = bsr;
    next_bsr_upd = bsr_upd;
    next_tdo = tdo;
    next_tdo_oe = tdo_oe;
    next_upd_pend = upd_pend;
    if (rise)
    begin
      case (state)
        sti_pkg::ST_CAP_IR: next_ir_sh = sti_pkg::IR_CAPTURE;
        // Bits enter at the top, so the leftmost bit is the last one shifted
        sti_pkg::ST_SH_IR: next_ir_sh = {tdi_s, ir_sh[2:1]};
        sti_pkg::ST_CAP_DR:
        begin
          case (sel)
            sti_pkg::SEL_ID: next_id_sh = sti_pkg::ID_VALUE;
            sti_pkg::SEL_BSR: next_bsr = ring_s2;
            default: next_byp = sti_pkg::BYPASS_CAPTURE;
          endcase
        end
        sti_pkg::ST_SH_DR:
        begin
          case (sel)
            sti_pkg::SEL_ID: next_id_sh = {tdi_s, id_sh[31:1]};
            sti_pkg::SEL_BSR: next_bsr = {tdi_s, bsr[BSR_LEN-1:1]};
            default: next_byp = tdi_s;
          endcase
        end
        default: next_state = step(state, tms_s);
      endcase
      if (state inside {sti_pkg::ST_CAP_IR, sti_pkg::ST_SH_IR,
                        sti_pkg::ST_CAP_DR, sti_pkg::ST_SH_DR})
      begin
        next_state = step(state, tms_s);
      end
    end
    // A fresh Update-IR fall in the same cycle as a push keeps the update pending
    if (push)
    begin
      next_ir = ir_sh;
      next_upd_pend = 1'b0;
    end
    if (fall)
    begin
      next_tdo_oe = (state == sti_pkg::ST_SH_IR) || (state == sti_pkg::ST_SH_DR);
      if (state == sti_pkg::ST_SH_IR)
      begin
        next_tdo = ir_sh[0];
      end
      else if (state == sti_pkg::ST_SH_DR)
      begin
        case (sel)
          sti_pkg::SEL_ID: next_tdo = id_sh[0];
          sti_pkg::SEL_BSR: next_tdo = bsr[0];
          default: next_tdo = byp;
        endcase
      end
      if (state == sti_pkg::ST_UPD_IR)
      begin
        next_upd_pend = 1'b1;
      end
      if (state == sti_pkg::ST_UPD_DR)
      begin
        next_bsr_upd = bsr;
      end
    end
    // Test-Logic-Reset wins over a held update
    if (state == sti_pkg::ST_RESET)
    begin
      next_ir = sti_pkg::IR_RESET;
      next_upd_pend = 1'b0;
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      state <= sti_pkg::ST_RESET;
      ir <= sti_pkg::IR_RESET;
      ir_sh <= sti_pkg::IR_CAPTURE;
      byp <= sti_pkg::BYPASS_CAPTURE;
      id_sh <= sti_pkg::ID_VALUE;
      bsr <= '0;
      bsr_upd <= '0;
      tdo <= sti_pkg::TDO_RESET;
      tdo_oe <= 1'b0;
      upd_pend <= 1'b0;
    end
    else
    begin
      state <= next_state;
      ir <= next_ir;
      ir_sh <= next_ir_sh;
      byp <= next_byp;
      id_sh <= next_id_sh;
      bsr <= next_bsr;
      bsr_upd <= next_bsr_upd;
      tdo <= next_tdo;
      tdo_oe <= next_tdo_oe;
      upd_pend <= next_upd_pend;
    end
  end

  logic float_q;
  logic drive_q;

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      float_q <= 1'b0;
      drive_q <= 1'b0;
    end
    else
    begin
      float_q <= (ir == sti_pkg::IR_SAMPLE_Z);
      drive_q <= (ir == sti_pkg::IR_EXTEST);
    end
  end

  assign tdo_o = tdo;
  assign tdo_oe_o = tdo_oe;
  assign outputs_float_o = float_q;
  // Sample and preload never touch the memory pins
  assign bsr_drive_o = drive_q;
  assign bsr_pins_o = bsr_upd;

  sti_fifo #(
    .WIDTH(sti_pkg::IR_WIDTH),
    .DEPTH(LOG_DEPTH)
  ) sti_fifo_inst (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .in_valid_i(upd_pend),
    .in_ready_o(fifo_ready),
    .in_data_i(ir_sh),
    .out_valid_o(instr_valid_o),
    .out_ready_i(instr_ready_i),
    .out_data_o(instr_data_o)
  );

endmodule : sti_tap

`default_nettype wire
